/* tb/ssq_motor_model.sv */
/*
  Coarse power stage and motor plant answering the drive command.
  Assumes the command is registered on the same clock.
*/
`timescale 1ns/10ps
module ssq_motor_model (
  input  wire logic                clk,   // clock
  input  wire logic                rst_n, // reset, active low
  input  wire ssq_pkg::ssq_drive_t drive, // power stage command
  output logic signed [15:0]       speed  // shaft speed
);
  import ssq_pkg::*;
  // torque steps clamp at zero so braking never reverses the shaft
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed <= 16'sh0;
    end else if (drive.db_on) begin
      speed <= speed >>> 1;
    end else if (drive.trq_ref != 16'sh0) begin
      speed <= (speed > 16'sh8) ? speed - 16'sh8 : (speed < -16'sh8) ? speed + 16'sh8 : 16'sh0;
    end else if (drive.pwr_en) begin
      speed <= drive.spd_ref;
    end else begin
      speed <= speed + ((speed > 16'sh0) ? -16'sh1 : (speed < 16'sh0) ? 16'sh1 : 16'sh0);
    end
  end
endmodule

/* tb/ssq_sequencer_assertions.sv */
/*
  Port-level checker for the stop-mode sequencer, bound into ssq_sequencer.
  Assumes the bench starts a stop only from the run state.
*/
`timescale 1ns/10ps
module ssq_chk (
  input wire logic                MCLK,        // clock
  input wire logic                RST_N,       // reset, active low
  input wire logic                PSEL,        // apb select
  input wire logic                PENABLE,     // apb access
  input wire logic                PWRITE,      // apb direction
  input wire logic [15:0]         PADDR,       // apb address
  input wire logic [31:0]         PWDATA,      // apb write data
  input wire logic                PREADY,      // apb ready
  input wire logic                PSLVERR,     // apb error
  input wire logic signed [15:0]  MOTOR_SPEED, // shaft speed
  input wire ssq_pkg::ssq_drive_t DRIVE,       // power stage command
  input wire logic                STOPPED      // holding
);
  import ssq_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic [15:0] mode_q;
  logic        son_q;
  logic        halt_q;
  wire         acc = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire         sw = acc && PADDR == OFS_CTRL && !PWDATA[0] && !PWDATA[2] && son_q && !halt_q;
  wire         m_ok = $signed(PWDATA[15:0]) >= -16'sd4 && $signed(PWDATA[15:0]) <= 16'sd1;
  // shadow of accepted writes, so a stop is judged by the mode it started with
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= 16'h0000;
      son_q  <= 1'b0;
      halt_q <= 1'b0;
    end else if (acc && PADDR == OFS_STOP_MODE) begin
      mode_q <= PWDATA[15:0];
    end else if (acc && PADDR == OFS_CTRL) begin
      son_q  <= PWDATA[0];
      halt_q <= PWDATA[2];
    end
  end
  property p_coast;
    sw && !PWDATA[1] && mode_q == MODE_COAST |-> ##3 (!DRIVE.pwr_en && !DRIVE.db_on) [*8];
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop drove motor");
  property p_zero;
    sw && !PWDATA[1] && mode_q == MODE_ZERO_DB |-> ##3 DRIVE.pwr_en && DRIVE.spd_ref == 16'sh0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero stop not at zero");
  property p_ramp;
    sw && !PWDATA[1] && mode_q == MODE_RAMP_OFF |-> ##3 (DRIVE.pwr_en && DRIVE.spd_ref != 0) [*8];
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp stop dropped at once");
  property p_emg;
    DRIVE.trq_ref != 16'sh0 |-> DRIVE.trq_ref[15] != MOTOR_SPEED[15] || MOTOR_SPEED == 16'sh0;
  endproperty
  a_emg: assert property (p_emg) else $error("torque not opposing motion");
  property p_dbs;
    sw && !PWDATA[1] && mode_q == MODE_DB_DB |-> ##3 DRIVE.db_on && !DRIVE.pwr_en;
  endproperty
  a_dbs: assert property (p_dbs) else $error("brake stop not braking");
  property p_free;
    STOPPED && !DRIVE.pos_lock && !DRIVE.db_on |-> !DRIVE.pwr_en;
  endproperty
  a_free: assert property (p_free) else $error("free hold powered");
  property p_lock;
    DRIVE.pos_lock |-> DRIVE.pwr_en && DRIVE.spd_ref == 16'sh0;
  endproperty
  a_lock: assert property (p_lock) else $error("lock hold unpowered");
  property p_dbx;
    DRIVE.db_on |-> !DRIVE.pwr_en;
  endproperty
  a_dbx: assert property (p_dbx) else $error("brake short while powered");
  property p_merr;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_STOP_MODE && !m_ok |-> PSLVERR;
  endproperty
  a_merr: assert property (p_merr) else $error("bad stop mode accepted");
  property p_brk;
    sw && PWDATA[1] |-> ##3 DRIVE.pwr_en ##[1:1000] (STOPPED && DRIVE.db_on);
  endproperty
  a_brk: assert property (p_brk) else $error("brake stop not quick ramp");
  c_lock: cover property (STOPPED && DRIVE.pos_lock);
  c_err: cover property (PREADY && PSLVERR);
  c_brk: cover property (sw && PWDATA[1]);
endmodule
bind ssq_sequencer ssq_chk ssq_chk_inst (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MOTOR_SPEED(MOTOR_SPEED), .DRIVE(DRIVE), .STOPPED(STOPPED));

/* tb/tb.sv */
/*
  Self-checking bench for the stop-mode sequencer: apb master, plant model.
  Assumes the plant settles every stop within a few thousand cycles.
*/
`timescale 1ns/10ps
module tb;
  import ssq_pkg::*;
  logic               MCLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [15:0]        PADDR = 16'h0;
  logic [31:0]        PWDATA = 32'h0, PRDATA, rd;
  logic               PREADY, PSLVERR, STOPPED, err;
  logic signed [15:0] MOTOR_SPEED;
  logic [15:0]        run, m, modes [6];
  ssq_drive_t         DRIVE;
  int                 num_errors = 0, compares = 0;
  always #25 MCLK = ~MCLK;
  ssq_sequencer ssq_sequencer_inst (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MOTOR_SPEED(MOTOR_SPEED), .DRIVE(DRIVE), .STOPPED(STOPPED));
  ssq_motor_model ssq_motor_model_inst (.clk(MCLK), .rst_n(RST_N), .drive(DRIVE),
    .speed(MOTOR_SPEED));
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk_b(1'b0, 1'b1);
      tally_and_finish();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wait_stop();
    int n;
    for (n = 0; n < 4000 && STOPPED !== 1'b1; n++) @(posedge MCLK);
    if (n >= 4000) begin
      chk_b(1'b0, 1'b1);
      tally_and_finish();
    end
  endtask
  // expected status: quick 12, hold 9:8, decel 6:4, state 1:0 holding
  function automatic logic [31:0] exp_sts(input logic [15:0] md, input logic b);
    logic [2:0] d;
    d = (md == MODE_ZERO_DB) ? 3'd1 : (md == MODE_DB_DB) ? 3'd4 : (md == MODE_COAST) ? 3'd0 : 3'd2;
    if (b) d = 3'd2;
    return (32'(b || md == MODE_QRAMP_DB) << 12) | (32'(b || md[15]) << 9) | (32'(d) << 4) | 3;
  endfunction
  initial begin
    modes = '{MODE_QRAMP_DB, MODE_ZERO_DB, MODE_RAMP_DB, MODE_DB_DB, MODE_COAST, MODE_RAMP_OFF};
    void'($urandom(4260));
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    apb(1'b0, OFS_STOP_MODE, 32'h0);
    chk_w(rd, 32'h0);
    foreach (modes[i]) begin
      m = (i < 2) ? 16'(16'h0002 + 16'hfff9 * i) : 16'(16'h0002 + $urandom_range(0, 16'h7ff0));
      apb(1'b1, OFS_STOP_MODE, {16'h0, m});
      chk_b(err, 1'b1);
    end
    apb(1'b0, OFS_STOP_MODE, 32'h0);
    chk_w(rd, 32'h0);
    apb(1'b0, 16'h0100, 32'h0);
    chk_b(err, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h0);
    chk_b(err, 1'b1);
    run = 16'(16'h0100 + $urandom_range(0, 255));
    apb(1'b1, OFS_RUN_SPEED, {16'h0, run});
    for (int i = 0; i < 12; i++) begin
      m = modes[i % 6];
      apb(1'b1, OFS_STOP_MODE, {16'h0, m});
      apb(1'b0, OFS_STOP_MODE, 32'h0);
      chk_w(rd, {{16{m[15]}}, m});
      apb(1'b1, OFS_CTRL, 32'(i / 6) * 2 + 1);
      repeat (3) @(posedge MCLK);
      chk_b(DRIVE.pwr_en, 1'b1);
      chk_w({16'h0, DRIVE.spd_ref}, {16'h0, run});
      apb(1'b1, OFS_CTRL, 32'(i / 6) * 2);
      apb(1'b1, OFS_STOP_MODE, {16'h0, modes[$urandom_range(0, 5)]});
      wait_stop();
      apb(1'b0, OFS_STATUS, 32'h0);
      chk_w(rd & 32'h1373, exp_sts(m, i >= 6));
      chk_b(DRIVE.db_on, i >= 6 || m[15]);
      chk_b(DRIVE.pwr_en, 1'b0);
    end
    apb(1'b1, OFS_RUN_SPEED, {16'h0, -run});
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge MCLK);
    apb(1'b1, OFS_CTRL, 32'h0135);
    repeat (3) @(posedge MCLK);
    chk_w({16'h0, DRIVE.trq_ref}, {16'h0, RST_EMG_TRQ});
    wait_stop();
    chk_b(DRIVE.pos_lock, 1'b1);
    chk_b(DRIVE.pwr_en, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_w(rd & 32'h0373, 32'h0133);
    tally_and_finish();
  end
endmodule

/* verilog/ssq_mode_decode.sv */
/*
  Turns the servo-off stop mode, brake enable and halt request into a stop plan.
  Assumes the stop mode holds only legal codes; the register bus refuses others.
*/
`timescale 1ns/10ps
module ssq_mode_decode (
  input  wire logic [15:0]        stop_mode,  // servo-off stop mode code
  input  wire logic               brake_en,   // holding-brake output enabled
  input  wire logic               halt,       // software halt selects its own plan
  input  wire ssq_pkg::ssq_decel_t halt_decel, // deceleration for a halt
  input  wire ssq_pkg::ssq_hold_t  halt_hold,  // holding state for a halt
  output ssq_pkg::ssq_plan_t      plan        // decoded plan
);
  import ssq_pkg::*;

  always_comb begin
    plan = '{decel: DEC_COAST, hold: HOLD_FREE, quick: 1'b0};
    if (halt) begin
      plan = '{decel: halt_decel, hold: halt_hold, quick: 1'b1};
    end else if (brake_en) begin
      plan = '{decel: DEC_RAMP, hold: HOLD_DB, quick: 1'b1};
    end else begin
      case (stop_mode)
        MODE_QRAMP_DB: plan = '{decel: DEC_RAMP, hold: HOLD_DB, quick: 1'b1};
        MODE_ZERO_DB:  plan = '{decel: DEC_ZERO, hold: HOLD_DB, quick: 1'b0};
        MODE_RAMP_DB:  plan = '{decel: DEC_RAMP, hold: HOLD_DB, quick: 1'b0};
        MODE_DB_DB:    plan = '{decel: DEC_DB, hold: HOLD_DB, quick: 1'b0};
        MODE_RAMP_OFF: plan = '{decel: DEC_RAMP, hold: HOLD_FREE, quick: 1'b0};
        default:       plan = '{decel: DEC_COAST, hold: HOLD_FREE, quick: 1'b0};
      endcase
    end
  end

endmodule

/* verilog/ssq_pkg.sv */
/*
  Shared constants, enumerations and carriers for the servo stop-mode sequencer.
  Assumes a single 20 MHz clock and an APB register bus with 32-bit data.
*/
package ssq_pkg;

  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned CLK_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_NS  = 1000;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [15:0] OFS_CTRL      = 16'h0000;
  localparam logic [15:0] OFS_STATUS    = 16'h0004;
  localparam logic [15:0] OFS_RUN_SPEED = 16'h0008;
  localparam logic [15:0] OFS_RAMP_DEC  = 16'h000c;
  localparam logic [15:0] OFS_QSTOP_DEC = 16'h0010;
  localparam logic [15:0] OFS_ZERO_THR  = 16'h0014;
  localparam logic [15:0] OFS_EMG_TRQ   = 16'h0018;
  localparam logic [15:0] OFS_STOP_MODE = 16'h605c;

  localparam logic [15:0] RST_CTRL      = 16'h0000;
  localparam logic [15:0] RST_RUN_SPEED = 16'h0000;
  localparam logic [15:0] RST_RAMP_DEC  = 16'h0010;
  localparam logic [15:0] RST_QSTOP_DEC = 16'h0040;
  localparam logic [15:0] RST_ZERO_THR  = 16'h0004;
  localparam logic [15:0] RST_EMG_TRQ   = 16'h0100;
  localparam logic [15:0] RST_STOP_MODE = 16'h0000;

  localparam int unsigned CTL_SON_BIT   = 0;
  localparam int unsigned CTL_BRK_BIT   = 1;
  localparam int unsigned CTL_HALT_BIT  = 2;
  localparam int unsigned CTL_HDEC_LSB  = 4;
  localparam int unsigned CTL_HHOLD_LSB = 8;
  localparam logic [15:0] CTL_MASK      = 16'h0377;

  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_DEC_LSB   = 4;
  localparam int unsigned STS_HOLD_LSB  = 8;
  localparam int unsigned STS_QUICK_BIT = 12;
  localparam int unsigned STS_ZERO_BIT  = 13;

  localparam logic [15:0] MODE_QRAMP_DB = 16'hfffc;
  localparam logic [15:0] MODE_ZERO_DB  = 16'hfffd;
  localparam logic [15:0] MODE_RAMP_DB  = 16'hfffe;
  localparam logic [15:0] MODE_DB_DB    = 16'hffff;
  localparam logic [15:0] MODE_COAST    = 16'h0000;
  localparam logic [15:0] MODE_RAMP_OFF = 16'h0001;

  typedef enum logic [2:0] {DEC_COAST, DEC_ZERO, DEC_RAMP, DEC_EMG, DEC_DB} ssq_decel_t;
  typedef enum logic [1:0] {HOLD_FREE, HOLD_LOCK, HOLD_DB} ssq_hold_t;
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DECEL, ST_HOLD} ssq_state_t;

  typedef struct packed {
    ssq_decel_t decel;
    ssq_hold_t  hold;
    logic       quick;
  } ssq_plan_t;

  typedef struct packed {
    logic               pwr_en;
    logic               db_on;
    logic               pos_lock;
    logic signed [15:0] spd_ref;
    logic signed [15:0] trq_ref;
  } ssq_drive_t;

  function automatic logic [15:0] ssq_abs(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic ssq_mode_ok(input logic [15:0] m);
    return (m == MODE_QRAMP_DB) || (m == MODE_ZERO_DB) || (m == MODE_RAMP_DB) ||
           (m == MODE_DB_DB) || (m == MODE_COAST) || (m == MODE_RAMP_OFF);
  endfunction

endpackage

/* verilog/ssq_ramp.sv */
/*
  Speed ramp generator: loads a start value and walks it toward zero by a step
  once per microsecond tick. Assumes one clock and an active-low async reset.
*/
`timescale 1ns/10ps
module ssq_ramp (
  input  wire logic               clk,      // system clock
  input  wire logic               rst_n,    // async reset, active low
  input  wire logic               load,     // take load_val this cycle
  input  wire logic signed [15:0] load_val, // starting reference
  input  wire logic               run,      // ramp toward zero while high
  input  wire logic [15:0]        step,     // decrement per tick
  output logic signed [15:0]      ref_q,    // present ramp reference
  output logic                    at_zero   // reference has reached zero
);
  import ssq_pkg::*;

  logic [15:0] div_q;
  logic        tick;
  logic [15:0] mag;

  assign tick    = (div_q == 16'(TICK_CYC - 1));
  assign at_zero = (ref_q == 16'sh0000);
  assign mag     = ssq_abs(ref_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
    end else if (load || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // clamp at zero so a coarse step never overshoots into reverse motion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 16'sh0000;
    end else if (load) begin
      ref_q <= load_val;
    end else if (run && tick && !at_zero) begin
      if (mag <= step) begin
        ref_q <= 16'sh0000;
      end else if (ref_q[15]) begin
        ref_q <= ref_q + $signed(step);
      end else begin
        ref_q <= ref_q - $signed(step);
      end
    end
  end

endmodule

/* verilog/ssq_sequencer.sv */
/*
  Servo stop-mode sequencer top: APB register file, servo-on tracking and the
  stop sequence that drives the power stage command.
  Assumes MOTOR_SPEED is synchronous to MCLK and the power stage follows DRIVE.
*/
`timescale 1ns/10ps

// Summary of operation
// - Coast deceleration drops motor power at once and applies no braking.
// - Zero-speed deceleration commands zero speed at once, with no ramp, and holds it.
// - Ramp deceleration walks the speed reference smoothly down to zero.
// - Emergency-torque deceleration applies torque opposing motion until the motor stops.
// - Dynamic-brake deceleration shorts the motor through the brake for the whole stop.
// - A de-energized hold keeps the motor unpowered and free after it stops.
// - A position-lock hold keeps the motor powered and holding position after it stops.
// - A dynamic-brake hold keeps the motor unpowered with the brake short applied.
// - Withdrawal of servo-on by the host starts the stop chosen by the stop mode.
// - Stop modes -4..1 map to quick ramp/DB, zero/DB, ramp/DB, DB/DB, coast/free, ramp/free.
// - The stop mode resets to 0, coasting and then holding de-energized.
// - With the holding brake enabled every stop except a halt is a quick ramp ending in a DB hold.
module ssq_sequencer (
  input  wire logic               MCLK,        // 20 MHz system clock
  input  wire logic               RST_N,       // async reset, active low
  input  wire logic               PSEL,        // apb select
  input  wire logic               PENABLE,     // apb access phase
  input  wire logic               PWRITE,      // apb direction
  input  wire logic [15:0]        PADDR,       // apb byte address
  input  wire logic [31:0]        PWDATA,      // apb write data
  output logic [31:0]             PRDATA,      // apb read data
  output logic                    PREADY,      // apb ready
  output logic                    PSLVERR,     // apb error
  input  wire logic signed [15:0] MOTOR_SPEED, // measured shaft speed
  output ssq_pkg::ssq_drive_t     DRIVE,       // power stage command
  output logic                    STOPPED      // stop sequence finished, holding
);
  import ssq_pkg::*;

  logic [15:0]        ctrl_q;
  logic signed [15:0] run_speed_q;
  logic [15:0]        ramp_dec_q;
  logic [15:0]        qstop_dec_q;
  logic [15:0]        zero_thr_q;
  logic [15:0]        emg_trq_q;
  logic [15:0]        stop_mode_q;

  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;

  ssq_state_t         state_q;
  ssq_state_t         state_d;
  ssq_plan_t          plan_q;
  ssq_plan_t          plan_new;
  ssq_drive_t         drive_q;
  ssq_drive_t         drive_d;
  logic               stopped_q;
  logic               motor_still;

  logic               run_req;
  logic               ramp_load;
  logic signed [15:0] ramp_ref;
  logic               ramp_zero;
  logic [15:0]        ramp_step;

  logic               acc1;
  logic               wr_en;
  logic               hit;
  logic               bad_mode;
  logic [31:0]        rdata;
  logic [15:0]        status;

  // bus side
  assign acc1  = PSEL && PENABLE && !pready_q;
  assign wr_en = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (PADDR)
      OFS_CTRL:      rdata = {16'h0000, ctrl_q};
      OFS_STATUS:    rdata = {16'h0000, status};
      OFS_RUN_SPEED: rdata = {16'h0000, run_speed_q};
      OFS_RAMP_DEC:  rdata = {16'h0000, ramp_dec_q};
      OFS_QSTOP_DEC: rdata = {16'h0000, qstop_dec_q};
      OFS_ZERO_THR:  rdata = {16'h0000, zero_thr_q};
      OFS_EMG_TRQ:   rdata = {16'h0000, emg_trq_q};
      OFS_STOP_MODE: rdata = {{16{stop_mode_q[15]}}, stop_mode_q};
      default:       hit = 1'b0;
    endcase
  end

  // out-of-range stop codes are refused so the decoder only ever sees legal values
  assign bad_mode = PWRITE && (PADDR == OFS_STOP_MODE) && !ssq_mode_ok(PWDATA[15:0]);

  always_comb begin
    status = 16'h0000;
    status[STS_STATE_LSB +: 2] = state_q;
    status[STS_DEC_LSB +: 3]   = plan_q.decel;
    status[STS_HOLD_LSB +: 2]  = plan_q.hold;
    status[STS_QUICK_BIT]      = plan_q.quick;
    status[STS_ZERO_BIT]       = motor_still;
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (acc1) begin
      pready_q  <= 1'b1;
      pslverr_q <= !hit || bad_mode || (PWRITE && (PADDR == OFS_STATUS));
      prdata_q  <= PWRITE ? 32'h0000_0000 : rdata;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_en && PADDR == OFS_CTRL) begin
      ctrl_q <= PWDATA[15:0] & CTL_MASK;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_mode_q <= RST_STOP_MODE;
    end else if (wr_en && PADDR == OFS_STOP_MODE) begin
      stop_mode_q <= PWDATA[15:0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      run_speed_q <= RST_RUN_SPEED;
      ramp_dec_q  <= RST_RAMP_DEC;
      qstop_dec_q <= RST_QSTOP_DEC;
      zero_thr_q  <= RST_ZERO_THR;
      emg_trq_q   <= RST_EMG_TRQ;
    end else if (wr_en) begin
      case (PADDR)
        OFS_RUN_SPEED: run_speed_q <= PWDATA[15:0];
        OFS_RAMP_DEC:  ramp_dec_q  <= PWDATA[15:0];
        OFS_QSTOP_DEC: qstop_dec_q <= PWDATA[15:0];
        OFS_ZERO_THR:  zero_thr_q  <= PWDATA[15:0];
        OFS_EMG_TRQ:   emg_trq_q   <= PWDATA[15:0];
        default:       ;
      endcase
    end
  end

  // plan decoding and latching
  ssq_mode_decode u_decode (
    .stop_mode  (stop_mode_q),
    .brake_en   (ctrl_q[CTL_BRK_BIT]),
    .halt       (ctrl_q[CTL_HALT_BIT]),
    .halt_decel (ssq_decel_t'(ctrl_q[CTL_HDEC_LSB +: 3])),
    .halt_hold  (ssq_hold_t'(ctrl_q[CTL_HHOLD_LSB +: 2])),
    .plan       (plan_new)
  );

  assign run_req     = ctrl_q[CTL_SON_BIT] && !ctrl_q[CTL_HALT_BIT];
  assign motor_still = ssq_abs(MOTOR_SPEED) <= zero_thr_q;
  assign ramp_load   = (state_q == ST_RUN) && !run_req;
  assign ramp_step   = plan_q.quick ? qstop_dec_q : ramp_dec_q;

  // the plan is frozen for the whole stop; later stop-mode and control writes reach the plan only at the next one
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      plan_q <= '{decel: DEC_COAST, hold: HOLD_FREE, quick: 1'b0};
    end else if (ramp_load) begin
      plan_q <= plan_new;
    end
  end

  ssq_ramp u_ramp (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .load     (ramp_load),
    .load_val (drive_q.spd_ref),
    .run      (state_q == ST_DECEL && plan_q.decel == DEC_RAMP),
    .step     (ramp_step),
    .ref_q    (ramp_ref),
    .at_zero  (ramp_zero)
  );

  // stop sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (run_req) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_req) begin
          state_d = ST_DECEL;
        end
      end
      ST_DECEL: begin
        // a ramp finishes only when both the reference and the shaft are at rest
        if (motor_still && (plan_q.decel != DEC_RAMP || ramp_zero)) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (run_req) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // power stage command for the present state
  always_comb begin
    drive_d = '{pwr_en: 1'b0, db_on: 1'b0, pos_lock: 1'b0, spd_ref: 16'sh0000,
                trq_ref: 16'sh0000};
    case (state_q)
      ST_OFF: begin
        drive_d.pwr_en = 1'b0;
      end
      ST_RUN: begin
        drive_d.pwr_en  = 1'b1;
        drive_d.spd_ref = run_speed_q;
      end
      ST_DECEL: begin
        case (plan_q.decel)
          DEC_COAST: begin
            drive_d.pwr_en = 1'b0;
          end
          DEC_ZERO: begin
            drive_d.pwr_en  = 1'b1;
            drive_d.spd_ref = 16'sh0000;
          end
          DEC_RAMP: begin
            drive_d.pwr_en  = 1'b1;
            drive_d.spd_ref = ramp_ref;
          end
          DEC_EMG: begin
            drive_d.pwr_en  = 1'b1;
            // torque opposes the sign of the measured speed
            drive_d.trq_ref = MOTOR_SPEED[15] ? $signed(emg_trq_q)
                                              : 16'(-$signed(emg_trq_q));
          end
          DEC_DB: begin
            drive_d.db_on = 1'b1;
          end
          default: begin
            drive_d.pwr_en = 1'b0;
          end
        endcase
      end
      ST_HOLD: begin
        case (plan_q.hold)
          HOLD_FREE: begin
            drive_d.pwr_en = 1'b0;
          end
          HOLD_LOCK: begin
            drive_d.pwr_en   = 1'b1;
            drive_d.pos_lock = 1'b1;
          end
          HOLD_DB: begin
            drive_d.db_on = 1'b1;
          end
          default: begin
            drive_d.pwr_en = 1'b0;
          end
        endcase
      end
      default: begin
        drive_d.pwr_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      drive_q   <= '{pwr_en: 1'b0, db_on: 1'b0, pos_lock: 1'b0, spd_ref: 16'sh0000,
                     trq_ref: 16'sh0000};
      stopped_q <= 1'b0;
    end else begin
      drive_q   <= drive_d;
      stopped_q <= (state_q == ST_HOLD);
    end
  end

  assign DRIVE   = drive_q;
  assign STOPPED = stopped_q;
  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;

endmodule
